// File: rtl/fcf_dev.sv
/*
  Device end: task-file registers, 48-bit cache flush and format track
  execution, a four-entry write-cache tag store and a media write port.
  Assumes the media side answers each med_req with one med_ack pulse,
  and that task-file strobes come from logic on clk.
*/
// The AHB-Lite slave port and the register offsets were decided locally.
// How it works
// RULE1: command EAh starts a cache flush
// RULE2: flush writes every pending cache entry to media
// RULE3: busy stays high until flush ends or fails
// RULE4: good end shows ready and seek complete set
// RULE5: flush disabled means command aborted
// RULE6: host sets drive/head top bits, rest unused
// RULE7: write error aborts, failing address in registers
// RULE8: next flush continues after the failing sector
// RULE9: command 50h is format track
// RULE10: format writes a fixed fill pattern
// RULE11: one sector of data follows, sector-write handshake
// RULE12: format ignores the received sector data
// RULE13: LBA mode takes count, zero means 256
// RULE14: host places start address in address registers
// RULE15: host should avoid format track; still handled
// RULE16: abort sets error flag and abort bit, busy clear
`timescale 1ns/100ps
`include "fcf_regs.svh"
module fcf_dev import fcf_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  fcf_tf_if.dev tf,
  input wire logic flush_ext_en,
  input wire logic cache_put,
  input wire fcf_lba_t cache_lba,
  output logic cache_full,
  output logic med_req,
  output fcf_lba_t med_lba,
  output logic med_fill,
  output logic [7:0] med_pattern,
  input wire logic med_ack,
  input wire logic med_err
);
  localparam int DEPTH = 4;

  fcf_dev_e st_r;
  logic [7:0] feat_r, cnt_r, lo_r, mid_r, hi_r, lo_p_r, mid_p_r, hi_p_r, dh_r, err_r;
  logic busy_flag_r, drq_r, seek_complete_flag_r, errf_r;
  logic [7:0] wcnt_r;
  logic [8:0] rem_r;
  fcf_lba_t cur_lba_r;
  logic [1:0] pick_r;
  logic med_req_r, med_fill_r, cache_full_r;
  logic [DEPTH-1:0] ent_v_r;
  logic [DEPTH-1:0] ent_v_nxt;
  fcf_lba_t ent_lba_r [DEPTH];
  logic [15:0] tf_rdata_r;
  logic tf_rack_r;

  // lowest set bit; used for both the free slot and the next pending entry
  function automatic logic [2:0] first_set(input logic [DEPTH-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = DEPTH - 1; i >= 0; i--)
    begin
      if (v[i])
        r = {1'b1, 2'(i)};
    end
    return r;
  endfunction : first_set

  wire [2:0] pend = first_set(ent_v_r);
  wire [2:0] free = first_set(~ent_v_r);
  wire idle = (st_r == FCF_D_IDLE);
  wire reg_wr = tf.tf_we && idle;
  wire cmd_wr = reg_wr && (tf.tf_addr == `FCF_TF_CMD);
  wire is_flush = (tf.tf_wdata[7:0] == `FCF_CMD_FLUSH_EXT); // RULE1
  wire is_fmt = (tf.tf_wdata[7:0] == `FCF_CMD_FORMAT); // RULE9
  wire flush_go = cmd_wr && is_flush && flush_ext_en;
  wire fmt_go = cmd_wr && is_fmt;
  wire cmd_abort = cmd_wr && !flush_go && !fmt_go; // RULE5
  wire data_wr = tf.tf_we && (st_r == FCF_D_XFER) && (tf.tf_addr == `FCF_TF_DATA);
  wire ack_bad = (st_r == FCF_D_WAIT) && med_ack && med_err;
  wire flush_ack = (st_r == FCF_D_WAIT) && med_ack && !med_fill_r;
  wire lba_mode = dh_r[`FCF_DH_LBA];
  // sector number byte only counts in LBA mode; CHS formats a whole track
  wire fcf_lba_t fmt_start = lba_mode ? {20'h0, dh_r[3:0], hi_r, mid_r, lo_r}
    : {24'h0, dh_r[3:0], hi_r, mid_r, 4'h0};
  wire [8:0] fmt_count = !lba_mode ? `FCF_TRACK_SECTORS
    : (cnt_r == 8'h00) ? `FCF_ZERO_COUNT : {1'b0, cnt_r}; // RULE13
  wire [DEPTH-1:0] put_mask = (cache_put && free[2]) ? (DEPTH'(1) << free[1:0]) : '0;
  wire [DEPTH-1:0] clr_mask = flush_ack ? (DEPTH'(1) << pick_r) : '0;
  wire [7:0] status = {busy_flag_r, 1'b1, 1'b0, seek_complete_flag_r, drq_r, 2'b00, errf_r};
  wire [7:0] rd_byte = (tf.tf_addr == `FCF_TF_ERR) ? err_r
    : (tf.tf_addr == `FCF_TF_SECCNT) ? cnt_r
    : (tf.tf_addr == `FCF_TF_LBA_LO) ? lo_r
    : (tf.tf_addr == `FCF_TF_LBA_MID) ? mid_r
    : (tf.tf_addr == `FCF_TF_LBA_HI) ? hi_r
    : (tf.tf_addr == `FCF_TF_DRVHD) ? dh_r
    : (tf.tf_addr == `FCF_TF_CMD) ? status
    : (tf.tf_addr == `FCF_TF_LBA_LO_P) ? lo_p_r
    : (tf.tf_addr == `FCF_TF_LBA_MID_P) ? mid_p_r
    : (tf.tf_addr == `FCF_TF_LBA_HI_P) ? hi_p_r
    : 8'h00;

  // the failing entry is dropped too, so the next flush resumes past it
  assign ent_v_nxt = (ent_v_r | put_mask) & ~clr_mask; // RULE8

  assign cache_full = cache_full_r;
  assign med_req = med_req_r;
  assign med_lba = cur_lba_r;
  assign med_fill = med_fill_r;
  assign med_pattern = `FCF_FILL_PATTERN; // RULE10
  assign tf.tf_rdata = tf_rdata_r;
  assign tf.tf_rack = tf_rack_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ent_v_r <= '0;
      cache_full_r <= 1'b0;
    end
    else
    begin
      ent_v_r <= ent_v_nxt;
      cache_full_r <= &ent_v_nxt;
    end
  end

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        ent_lba_r[i] <= '0;
      else if (put_mask[i])
        ent_lba_r[i] <= cache_lba;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tf_rack_r <= 1'b0;
      tf_rdata_r <= 16'h0000;
    end
    else
    begin
      tf_rack_r <= tf.tf_re;
      tf_rdata_r <= {8'h00, rd_byte};
    end
  end

  // task-file bytes; writing an address byte keeps the old one as upper half
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {feat_r, cnt_r, lo_r, mid_r, hi_r} <= {5{`FCF_RESET_BYTE}};
      {lo_p_r, mid_p_r, hi_p_r, dh_r, err_r} <= {5{`FCF_RESET_BYTE}};
    end
    else if (ack_bad)
    begin
      {hi_p_r, mid_p_r, lo_p_r, hi_r, mid_r, lo_r} <= cur_lba_r; // RULE7
      err_r <= `FCF_ERR_ABRT; // RULE16
    end
    else if (cmd_abort)
      err_r <= `FCF_ERR_ABRT; // RULE16
    else if (reg_wr)
    begin
      case (tf.tf_addr)
        `FCF_TF_ERR: feat_r <= tf.tf_wdata[7:0];
        `FCF_TF_SECCNT: cnt_r <= tf.tf_wdata[7:0];
        `FCF_TF_LBA_LO: {lo_p_r, lo_r} <= {lo_r, tf.tf_wdata[7:0]};
        `FCF_TF_LBA_MID: {mid_p_r, mid_r} <= {mid_r, tf.tf_wdata[7:0]};
        `FCF_TF_LBA_HI: {hi_p_r, hi_r} <= {hi_r, tf.tf_wdata[7:0]};
        `FCF_TF_DRVHD: dh_r <= tf.tf_wdata[7:0];
        `FCF_TF_CMD: err_r <= 8'h00;
        default: err_r <= err_r;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= FCF_D_IDLE;
      {busy_flag_r, drq_r, seek_complete_flag_r, errf_r, med_req_r, med_fill_r} <= 6'h00;
      wcnt_r <= 8'h00;
      rem_r <= 9'h000;
      cur_lba_r <= '0;
      pick_r <= 2'h0;
    end
    else
    begin
      unique case (st_r)
        FCF_D_IDLE:
        begin
          if (flush_go)
          begin
            st_r <= FCF_D_FLUSH;
            busy_flag_r <= 1'b1; // RULE3
            errf_r <= 1'b0;
          end
          else if (fmt_go)
          begin
            st_r <= FCF_D_XFER;
            drq_r <= 1'b1; // RULE11
            errf_r <= 1'b0;
            wcnt_r <= 8'h00;
          end
          else if (cmd_abort)
            errf_r <= 1'b1; // RULE16
        end
        FCF_D_XFER:
        begin
          // words are counted and thrown away; the pattern alone is written
          if (data_wr)
          begin
            wcnt_r <= wcnt_r + 8'h01; // RULE12
            if (wcnt_r == `FCF_LAST_WORD)
            begin
              st_r <= FCF_D_FMT;
              drq_r <= 1'b0;
              busy_flag_r <= 1'b1;
              cur_lba_r <= fmt_start; // RULE14
              rem_r <= fmt_count;
            end
          end
        end
        FCF_D_FLUSH:
        begin
          if (pend[2])
          begin
            st_r <= FCF_D_WAIT;
            med_req_r <= 1'b1; // RULE2
            med_fill_r <= 1'b0;
            cur_lba_r <= ent_lba_r[pend[1:0]];
            pick_r <= pend[1:0];
          end
          else
          begin
            st_r <= FCF_D_IDLE;
            busy_flag_r <= 1'b0; // RULE3
            seek_complete_flag_r <= 1'b1; // RULE4
          end
        end
        FCF_D_FMT:
        begin
          if (rem_r != 9'h000)
          begin
            st_r <= FCF_D_WAIT;
            med_req_r <= 1'b1;
            med_fill_r <= 1'b1;
          end
          else
          begin
            st_r <= FCF_D_IDLE;
            busy_flag_r <= 1'b0;
            seek_complete_flag_r <= 1'b1;
          end
        end
        FCF_D_WAIT:
        begin
          if (med_ack)
          begin
            med_req_r <= 1'b0;
            if (med_err)
            begin
              st_r <= FCF_D_IDLE;
              errf_r <= 1'b1; // RULE7
              busy_flag_r <= 1'b0; // RULE16
            end
            else if (med_fill_r)
            begin
              st_r <= FCF_D_FMT;
              cur_lba_r <= cur_lba_r + 48'h1;
              rem_r <= rem_r - 9'h001;
            end
            else
              st_r <= FCF_D_FLUSH;
          end
        end
      endcase
    end
  end
endmodule : fcf_dev

// File: rtl/fcf_regs.svh
/*
  Constants of the cache flush / format track command block: task-file register
  addresses, command codes, status and error bit positions, and the host
  controller's own AHB-Lite register offsets.
  Assumes it is included by bare name wherever these constants are used.
*/
`ifndef FCF_REGS_SVH
`define FCF_REGS_SVH

// task-file addresses; 8..A read back the upper halves of the address bytes
`define FCF_TF_DATA 4'h0
`define FCF_TF_ERR 4'h1
`define FCF_TF_SECCNT 4'h2
`define FCF_TF_LBA_LO 4'h3
`define FCF_TF_LBA_MID 4'h4
`define FCF_TF_LBA_HI 4'h5
`define FCF_TF_DRVHD 4'h6
`define FCF_TF_CMD 4'h7
`define FCF_TF_LBA_LO_P 4'h8
`define FCF_TF_LBA_MID_P 4'h9
`define FCF_TF_LBA_HI_P 4'hA

`define FCF_CMD_FLUSH_EXT 8'hEA
`define FCF_CMD_FORMAT 8'h50

// status byte bits
`define FCF_ST_BUSY_FLAG 7
`define FCF_ST_RDY 6
`define FCF_ST_SEEK_COMPLETE_FLAG 4
`define FCF_ST_DRQ 3
`define FCF_ST_ERR 0
// error register abort bit, drive/head fields
`define FCF_ERR_ABRT 8'h04
`define FCF_DH_LBA 6
`define FCF_DH_DRV 4
`define FCF_DH_FIXED 3'h7

`define FCF_FILL_PATTERN 8'hFF
`define FCF_LAST_WORD 8'hFF
`define FCF_ZERO_COUNT 9'h100
`define FCF_TRACK_SECTORS 9'h020
`define FCF_RESET_BYTE 8'h00

// host controller registers, byte offsets on AHB-Lite
`define FCF_HR_CTRL 8'h00
`define FCF_HR_SECCNT 8'h04
`define FCF_HR_LBA 8'h08
`define FCF_HR_STAT 8'h0C
`define FCF_HR_FAIL_LO 8'h10
`define FCF_HR_FAIL_HI 8'h14
`define FCF_HR_IRQ_STAT 8'h18
`define FCF_HR_IRQ_MASK 8'h1C
`define FCF_HSEQ_LAST 3'h6
`define FCF_HERR_LAST 3'h6

`endif

// File: rtl/fcf_pkg.sv
/*
  Types shared by both ends of the command block.
  Assumes nothing of its surroundings.
*/
package fcf_pkg;
  typedef logic [47:0] fcf_lba_t;
  typedef enum logic [2:0] {FCF_D_IDLE, FCF_D_XFER, FCF_D_FLUSH, FCF_D_FMT, FCF_D_WAIT} fcf_dev_e;
  typedef enum logic [2:0] {FCF_H_IDLE, FCF_H_WR, FCF_H_POLL, FCF_H_PWAIT, FCF_H_DATA, FCF_H_ERD,
    FCF_H_EWAIT} fcf_host_e;
endpackage : fcf_pkg

// File: rtl/fcf_tf_if.sv
/*
  Task-file link between host controller and device: register write strobe,
  register read strobe and read answer.
  Assumes both ends run on the same clk.
*/
`timescale 1ns/100ps
interface fcf_tf_if;
  logic tf_we;
  logic tf_re;
  logic [3:0] tf_addr;
  logic [15:0] tf_wdata;
  logic [15:0] tf_rdata;
  logic tf_rack;
  modport dev (input tf_we, input tf_re, input tf_addr, input tf_wdata, output tf_rdata, output tf_rack);
  modport host (output tf_we, output tf_re, output tf_addr, output tf_wdata, input tf_rdata, input tf_rack);
endinterface : fcf_tf_if

// File: rtl/fcf_host.sv
/*
  Host end: AHB-Lite register slave that issues flush-ext and format track
  commands over the task-file link, polls status, feeds the format sector
  and collects the failing address after an abort.
  Assumes a single AHB-Lite master doing whole-word single transfers.
*/
`timescale 1ns/100ps
`include "fcf_regs.svh"
module fcf_host import fcf_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  fcf_tf_if.host tf
);
  fcf_host_e st_r;
  logic [9:0] ctrl_r;
  logic [7:0] scnt_r, tfstat_r, tferr_r;
  logic [27:0] lba_r;
  logic [47:0] fail_r;
  logic [1:0] ist_r, imsk_r;
  logic irq_r, a_wr_r, we_r, re_r, hrdy_r;
  logic [7:0] a_off_r, wcnt_r;
  logic [31:0] hrdata_r;
  logic [2:0] step_r;
  logic [3:0] addr_r;
  logic [15:0] wdata_r;

  // read order after an abort: error byte, then address bytes low to high
  function automatic logic [3:0] err_addr(input logic [2:0] s);
    return (s == 3'h0) ? `FCF_TF_ERR : (s == 3'h1) ? `FCF_TF_LBA_LO : (s == 3'h2) ? `FCF_TF_LBA_MID
      : (s == 3'h3) ? `FCF_TF_LBA_HI : (s == 3'h4) ? `FCF_TF_LBA_LO_P
      : (s == 3'h5) ? `FCF_TF_LBA_MID_P : `FCF_TF_LBA_HI_P;
  endfunction : err_addr

  wire ap = hsel && htrans[1] && hready;
  wire w = a_wr_r;
  wire go = w && (a_off_r == `FCF_HR_CTRL) && (st_r == FCF_H_IDLE);
  wire is_flush = (ctrl_r[7:0] == `FCF_CMD_FLUSH_EXT);
  // flush needs 1 1 1 in the top bits; format carries the start address
  wire [7:0] dh_byte = is_flush ? {`FCF_DH_FIXED, ctrl_r[9], 4'h0} // RULE6
    : {1'b1, ctrl_r[8], 1'b1, ctrl_r[9], lba_r[27:24]}; // RULE14
  wire [3:0] seq_addr = (step_r == 3'h0) ? `FCF_TF_ERR : (step_r == 3'h1) ? `FCF_TF_SECCNT
    : (step_r == 3'h2) ? `FCF_TF_LBA_LO : (step_r == 3'h3) ? `FCF_TF_LBA_MID
    : (step_r == 3'h4) ? `FCF_TF_LBA_HI : (step_r == 3'h5) ? `FCF_TF_DRVHD : `FCF_TF_CMD;
  wire [7:0] seq_data = is_flush ? ((step_r == 3'h5) ? dh_byte : (step_r == 3'h6) ? ctrl_r[7:0] : 8'h00)
    : (step_r == 3'h1) ? scnt_r : (step_r == 3'h2) ? lba_r[7:0] : (step_r == 3'h3) ? lba_r[15:8]
    : (step_r == 3'h4) ? lba_r[23:16] : (step_r == 3'h5) ? dh_byte : (step_r == 3'h6) ? ctrl_r[7:0] : 8'h00;
  wire rack = (st_r == FCF_H_PWAIT) && tf.tf_rack;
  wire rd_busy = tf.tf_rdata[`FCF_ST_BUSY_FLAG];
  wire ev_done = rack && !rd_busy && !tf.tf_rdata[`FCF_ST_DRQ] && !tf.tf_rdata[`FCF_ST_ERR];
  wire ev_err = (st_r == FCF_H_EWAIT) && tf.tf_rack && (step_r == `FCF_HERR_LAST);
  wire [1:0] ist_nxt = (ist_r & ~((w && a_off_r == `FCF_HR_IRQ_STAT) ? hwdata[1:0] : 2'b00))
    | {ev_err, ev_done};
  wire [31:0] rd_mux = (haddr[7:0] == `FCF_HR_CTRL) ? {22'h0, ctrl_r}
    : (haddr[7:0] == `FCF_HR_SECCNT) ? {24'h0, scnt_r}
    : (haddr[7:0] == `FCF_HR_LBA) ? {4'h0, lba_r}
    : (haddr[7:0] == `FCF_HR_STAT) ? {8'h0, tferr_r, tfstat_r, 7'h0, st_r != FCF_H_IDLE}
    : (haddr[7:0] == `FCF_HR_FAIL_LO) ? fail_r[31:0]
    : (haddr[7:0] == `FCF_HR_FAIL_HI) ? {16'h0, fail_r[47:32]}
    : (haddr[7:0] == `FCF_HR_IRQ_STAT) ? {30'h0, ist_r}
    : (haddr[7:0] == `FCF_HR_IRQ_MASK) ? {30'h0, imsk_r} : 32'h0;

  assign hreadyout = hrdy_r;
  assign hrdata = hrdata_r;
  assign hresp = 1'b0 & hrdy_r;
  assign irq = irq_r;
  assign tf.tf_we = we_r;
  assign tf.tf_re = re_r;
  assign tf.tf_addr = addr_r;
  assign tf.tf_wdata = wdata_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {hrdy_r, a_wr_r, a_off_r, hrdata_r} <= {1'b1, 1'b0, 8'h00, 32'h0};
      {ist_r, imsk_r, irq_r} <= 5'h00;
    end
    else
    begin
      a_wr_r <= ap && hwrite;
      a_off_r <= haddr[7:0];
      hrdata_r <= (ap && !hwrite) ? rd_mux : 32'h0;
      ist_r <= ist_nxt;
      irq_r <= |(ist_nxt & imsk_r);
      if (w && a_off_r == `FCF_HR_IRQ_MASK)
        imsk_r <= hwdata[1:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {ctrl_r, scnt_r, lba_r} <= 46'h0;
    end
    else if (w && st_r == FCF_H_IDLE)
    begin
      if (a_off_r == `FCF_HR_CTRL)
        ctrl_r <= hwdata[9:0];
      if (a_off_r == `FCF_HR_SECCNT)
        scnt_r <= hwdata[7:0];
      if (a_off_r == `FCF_HR_LBA)
        lba_r <= hwdata[27:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= FCF_H_IDLE;
      {we_r, re_r, addr_r, wdata_r} <= 22'h0;
      {step_r, wcnt_r, tfstat_r, tferr_r, fail_r} <= 75'h0;
    end
    else
    begin
      unique case (st_r)
        FCF_H_IDLE:
          if (go)
          begin
            st_r <= FCF_H_WR;
            step_r <= 3'h0;
          end
        FCF_H_WR:
        begin
          we_r <= 1'b1;
          addr_r <= seq_addr;
          wdata_r <= {8'h00, seq_data};
          step_r <= step_r + 3'h1;
          if (step_r == `FCF_HSEQ_LAST)
            st_r <= FCF_H_POLL;
        end
        FCF_H_POLL:
        begin
          we_r <= 1'b0;
          re_r <= 1'b1;
          addr_r <= `FCF_TF_CMD;
          st_r <= FCF_H_PWAIT;
        end
        FCF_H_PWAIT:
        begin
          re_r <= 1'b0;
          if (tf.tf_rack)
          begin
            tfstat_r <= tf.tf_rdata[7:0];
            if (rd_busy)
              st_r <= FCF_H_POLL;
            else if (tf.tf_rdata[`FCF_ST_DRQ])
            begin
              st_r <= FCF_H_DATA;
              wcnt_r <= 8'h00;
            end
            else if (tf.tf_rdata[`FCF_ST_ERR])
            begin
              st_r <= FCF_H_ERD;
              step_r <= 3'h0;
            end
            else
              st_r <= FCF_H_IDLE;
          end
        end
        FCF_H_DATA:
        begin
          // filler sector: the device discards it
          we_r <= 1'b1;
          addr_r <= `FCF_TF_DATA;
          wdata_r <= 16'h0000;
          wcnt_r <= wcnt_r + 8'h01;
          if (wcnt_r == `FCF_LAST_WORD)
            st_r <= FCF_H_POLL;
        end
        FCF_H_ERD:
        begin
          re_r <= 1'b1;
          addr_r <= err_addr(step_r);
          st_r <= FCF_H_EWAIT;
        end
        FCF_H_EWAIT:
        begin
          re_r <= 1'b0;
          if (tf.tf_rack)
          begin
            if (step_r == 3'h0)
              tferr_r <= tf.tf_rdata[7:0];
            else
              fail_r <= {tf.tf_rdata[7:0], fail_r[47:8]};
            step_r <= step_r + 3'h1;
            st_r <= (step_r == `FCF_HERR_LAST) ? FCF_H_IDLE : FCF_H_ERD;
          end
        end
      endcase
    end
  end
endmodule : fcf_host

// File: sim/fcf_monitor.sv
/*
  Concurrent checks on the task-file link between the host end and the device end.
  Assumes both ends run on clk, with rst asynchronous and active high.
*/
`timescale 1ns/100ps
`include "fcf_regs.svh"
module fcf_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic tf_we,
  input wire logic tf_re,
  input wire logic [3:0] tf_addr,
  input wire logic [15:0] tf_wdata,
  input wire logic [15:0] tf_rdata,
  input wire logic tf_rack
);
  logic [3:0] raddr_r;
  logic flush_r;
  logic fmt_r;
  logic err_r;
  logic [8:0] dcnt_r;
  wire cmd_wr = tf_we && tf_addr == `FCF_TF_CMD;
  wire data_wr = tf_we && tf_addr == `FCF_TF_DATA;
  // rack comes one cycle after re, so raddr_r still names the register being answered
  wire st_rd = tf_rack && raddr_r == `FCF_TF_CMD;
  wire er_rd = tf_rack && raddr_r == `FCF_TF_ERR;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      raddr_r <= 4'h0;
      flush_r <= 1'b0;
      fmt_r <= 1'b0;
      err_r <= 1'b0;
      dcnt_r <= 9'h000;
    end
    else
    begin
      raddr_r <= tf_re ? tf_addr : raddr_r;
      flush_r <= cmd_wr ? tf_wdata[7:0] == `FCF_CMD_FLUSH_EXT : flush_r;
      fmt_r <= cmd_wr ? tf_wdata[7:0] == `FCF_CMD_FORMAT : fmt_r;
      err_r <= cmd_wr ? 1'b0 : (err_r || (st_rd && tf_rdata[`FCF_ST_ERR]));
      dcnt_r <= cmd_wr ? 9'h000 : (data_wr ? dcnt_r + 9'h001 : dcnt_r);
    end

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_hi_wr;
    tf_we && tf_addr == `FCF_TF_LBA_HI;
  endsequence
  sequence s_dh_wr;
    tf_we && tf_addr == `FCF_TF_DRVHD;
  endsequence
  sequence s_flush_wr;
    cmd_wr && tf_wdata[7:0] == `FCF_CMD_FLUSH_EXT;
  endsequence

  a_read_answer: assert property (tf_re |=> tf_rack)
    else $error("task-file read got no answer in the next cycle");
  a_rack_cause: assert property (tf_rack |-> $past(tf_re) && tf_rdata[15:8] == 8'h00)
    else $error("read answer without a read strobe or with upper byte set");
  a_drvhd_frame: assert property (s_dh_wr ##1 s_flush_wr |-> $past(tf_wdata[7:5]) == `FCF_DH_FIXED)
    else $error("flush issued without fixed top bits in drive/head");
  a_unused_zero: assert property (s_hi_wr ##1 s_dh_wr ##1 s_flush_wr |-> $past(tf_wdata, 2) == 16'h0000)
    else $error("flush issued with a nonzero address byte");
  a_done_flags: assert property (st_rd && flush_r && !tf_rdata[7] && !tf_rdata[0] |-> tf_rdata[6] && tf_rdata[4])
    else $error("flush ended without ready and seek complete");
  a_busy_clean: assert property (st_rd && tf_rdata[`FCF_ST_BUSY_FLAG] |-> !tf_rdata[`FCF_ST_ERR])
    else $error("busy shown together with error");
  a_err_not_busy: assert property (st_rd && tf_rdata[`FCF_ST_ERR] |-> !tf_rdata[`FCF_ST_BUSY_FLAG])
    else $error("error shown while still busy");
  a_abort_code: assert property (er_rd && err_r |-> tf_rdata[7:0] == `FCF_ERR_ABRT)
    else $error("error register lacks the abort code");
  a_fmt_drq: assert property (st_rd && fmt_r && dcnt_r == 9'h000 |-> tf_rdata[`FCF_ST_DRQ])
    else $error("format did not request its sector buffer");
  a_sector_len: assert property (data_wr |-> fmt_r && dcnt_r < 9'h100)
    else $error("data word outside a format buffer or beyond one sector");
endmodule : fcf_monitor

// File: sim/fcf_tb_top.sv
/*
  Testbench for the flush / format command block: both ends joined by the task-file link,
  AHB-Lite master tasks and a media responder.
  Assumes the design files and fcf_regs.svh are compiled alongside.
*/
`timescale 1ns/100ps
`include "fcf_regs.svh"
module fcf_tb_top import fcf_pkg::*; ();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, dly;
  logic [2:0] hsize;
  wire hready = hreadyout;
  logic flush_ext_en, cache_put, cache_full, med_req, med_fill, med_ack, med_err;
  fcf_lba_t cache_lba, med_lba;
  logic [7:0] med_pattern;
  int bad_count, cmp_count, n_med, err_idx, base, cyc;
  fcf_lba_t log_lba [0:511];
  logic log_fill [0:511];
  logic [31:0] f_cnt [0:2] = '{32'h00000003, 32'h00000000, 32'h00000005};
  logic [31:0] f_ctl [0:2] = '{32'h00000150, 32'h00000150, 32'h00000050};
  logic [31:0] f_lba [0:2] = '{32'h00123456, 32'h00FFFF00, 32'h00ABCDEF};
  fcf_lba_t f_first [0:2] = '{48'h000000123456, 48'h000000FFFF00, 48'h0000000ABCD0};
  int f_n [0:2] = '{3, 256, 32};

  fcf_tf_if tf_bus ();
  fcf_host fcf_host_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .irq(irq), .tf(tf_bus));
  fcf_dev fcf_dev_i (.clk(clk), .rst(rst), .tf(tf_bus), .flush_ext_en(flush_ext_en), .cache_put(cache_put),
    .cache_lba(cache_lba), .cache_full(cache_full), .med_req(med_req), .med_lba(med_lba), .med_fill(med_fill),
    .med_pattern(med_pattern), .med_ack(med_ack), .med_err(med_err));
  fcf_monitor fcf_monitor_i (.clk(clk), .rst(rst), .tf_we(tf_bus.tf_we), .tf_re(tf_bus.tf_re),
    .tf_addr(tf_bus.tf_addr), .tf_wdata(tf_bus.tf_wdata), .tf_rdata(tf_bus.tf_rdata), .tf_rack(tf_bus.tf_rack));

  always #2.5 clk = ~clk;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // media answers every third cycle; med_err toggles outside acks so a stale level never reads as valid
  always @(posedge clk)
    if (med_req && !med_ack && dly == 2'h2)
    begin
      med_ack <= 1'b1;
      med_err <= n_med == err_idx;
      dly <= 2'h0;
      log_lba[n_med] <= med_lba;
      log_fill[n_med] <= med_fill;
      if (med_fill)
        chk({40'h0, med_pattern}, 48'h0000000000FF);
      n_med <= n_med + 1;
    end
    else
    begin
      med_ack <= 1'b0;
      med_err <= ~med_err;
      dly <= (med_req && !med_ack) ? dly + 2'h1 : dly;
    end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      bad_count++;
      summarize();
    end
  end

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rdc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    chk({47'h0, hresp}, 48'h0);
    chk({16'h0000, rd & msk}, {16'h0000, exp});
  endtask : rdc

  task automatic put(input fcf_lba_t l);
    @(posedge clk);
    cache_put <= 1'b1;
    cache_lba <= l;
    @(posedge clk);
    cache_put <= 1'b0;
    cache_lba <= ~l;
  endtask : put

  // polling the event bits first keeps the wait independent of the mask setting
  task automatic wait_evt();
    rd = 32'h00000000;
    while (rd[1:0] === 2'b00)
      ahb(1'b0, `FCF_HR_IRQ_STAT, 32'h00000000);
    ahb(1'b0, `FCF_HR_STAT, 32'h00000000);
    while (rd[0] !== 1'b0)
      ahb(1'b0, `FCF_HR_STAT, 32'h00000000);
  endtask : wait_evt

  task automatic irq_ev(input logic [1:0] ev);
    rdc(`FCF_HR_IRQ_STAT, 32'h00000003, {30'h0, ev});
    chk({47'h0, irq}, 48'h1);
    ahb(1'b1, `FCF_HR_IRQ_STAT, {30'h0, ev});
    rdc(`FCF_HR_IRQ_STAT, 32'h00000003, 32'h00000000);
    chk({47'h0, irq}, 48'h0);
  endtask : irq_ev

  task automatic flush();
    base = n_med;
    ahb(1'b1, `FCF_HR_CTRL, {24'h000000, `FCF_CMD_FLUSH_EXT});
    wait_evt();
  endtask : flush

  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, cache_put, cache_lba, med_ack, med_err, dly} = '0;
    {bad_count, cmp_count, n_med, cyc} = '0;
    hsize = 3'b010;
    flush_ext_en = 1'b1;
    err_idx = -1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(`FCF_HR_IRQ_STAT, 32'hFFFFFFFF, 32'h00000000);
    rdc(8'h40, 32'hFFFFFFFF, 32'h00000000);
    ahb(1'b1, `FCF_HR_IRQ_MASK, 32'h00000003);
    for (int i = 0; i < 4; i++)
      put(48'hA00000000000 + 48'(i));
    repeat (2) @(posedge clk);
    chk({47'h0, cache_full}, 48'h1);
    flush();
    chk(48'(n_med - base), 48'h4);
    for (int i = 0; i < 4; i++)
    begin
      chk({47'h0, log_fill[base + i]}, 48'h0);
      chk(log_lba[base + i], 48'hA00000000000 + 48'(i));
    end
    rdc(`FCF_HR_STAT, 32'h0000FF01, 32'h00005000);
    irq_ev(2'b01);
    chk({47'h0, cache_full}, 48'h0);
    for (int i = 0; i < 3; i++)
      put(48'hA1B2C3D4E5F0 + 48'(i));
    err_idx = n_med + 1;
    flush();
    err_idx = -1;
    chk(48'(n_med - base), 48'h2);
    rdc(`FCF_HR_STAT, 32'h00FF8101, 32'h00040100);
    rdc(`FCF_HR_FAIL_LO, 32'hFFFFFFFF, 32'hC3D4E5F1);
    rdc(`FCF_HR_FAIL_HI, 32'h0000FFFF, 32'h0000A1B2);
    irq_ev(2'b10);
    flush();
    chk(48'(n_med - base), 48'h1);
    chk(log_lba[base], 48'hA1B2C3D4E5F2);
    rdc(`FCF_HR_STAT, 32'h0000FF01, 32'h00005000);
    irq_ev(2'b01);
    flush_ext_en <= 1'b0;
    ahb(1'b1, `FCF_HR_IRQ_MASK, 32'h00000000);
    put(48'h000000000777);
    flush();
    chk(48'(n_med - base), 48'h0);
    rdc(`FCF_HR_STAT, 32'h00FF8101, 32'h00040100);
    chk({47'h0, irq}, 48'h0);
    ahb(1'b1, `FCF_HR_IRQ_MASK, 32'h00000003);
    irq_ev(2'b10);
    flush_ext_en <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      ahb(1'b1, `FCF_HR_SECCNT, f_cnt[k]);
      ahb(1'b1, `FCF_HR_LBA, f_lba[k]);
      base = n_med;
      ahb(1'b1, `FCF_HR_CTRL, f_ctl[k]);
      wait_evt();
      chk(48'(n_med - base), 48'(f_n[k]));
      chk({47'h0, log_fill[base]}, 48'h1);
      chk(log_lba[base], f_first[k]);
      chk(log_lba[base + f_n[k] - 1], f_first[k] + 48'(f_n[k] - 1));
      rdc(`FCF_HR_STAT, 32'h0000FF09, 32'h00005000);
      irq_ev(2'b01);
    end
    summarize();
  end
endmodule : fcf_tb_top
